// >>> shared/acs_pkg.sv
// Constants and types of the analog channel scaling block
package acs_pkg;
  // ==========================================================
  // Sizes
  localparam int NUM_CH  = 8;
  localparam int NUM_PTS = 20;

  // ==========================================================
  // Register word addresses
  localparam logic [7:0] A_RES_FIRST = 8'h01;
  localparam logic [7:0] A_RES_LAST  = 8'h08;
  localparam logic [7:0] A_STATUS    = 8'h09;
  localparam logic [7:0] A_CFG_FIRST = 8'h28;
  localparam logic [7:0] A_CFG_LAST  = 8'h67;
  localparam logic [7:0] A_PT_FIRST  = 8'h70;
  localparam logic [7:0] A_PT_LAST   = 8'h97;

  // Field index inside a channel block
  localparam logic [2:0] F_RANGE  = 3'h0;
  localparam logic [2:0] F_CHAR   = 3'h1;
  localparam logic [2:0] F_CAL_LO = 3'h2;
  localparam logic [2:0] F_CAL_HI = 3'h3;
  localparam logic [2:0] F_EXT_LO = 3'h4;
  localparam logic [2:0] F_EXT_HI = 3'h5;
  localparam logic [2:0] F_NPTS   = 3'h6;

  // ==========================================================
  // Arithmetic constants
  localparam logic [15:0] PCT_SCALE  = 16'h03E8;
  localparam logic [15:0] ROUND_HALF = 16'h8000;
  localparam logic signed [15:0] SAT_MAX = 16'sh7FFF;
  localparam logic signed [15:0] SAT_MIN = 16'sh8000;
  localparam logic [4:0] MIN_PTS   = 5'h02;
  localparam logic [4:0] MAX_PTS   = 5'h14;
  localparam logic [5:0] DIV_COUNT = 6'h30;
  localparam logic [4:0] SQRT_TOP  = 5'h12;

  // Range start and span: current in uA, voltage in mV
  localparam logic [15:0] S_4MA  = 16'h0FA0;
  localparam logic [15:0] W_16MA = 16'h3E80;
  localparam logic [15:0] W_20MA = 16'h4E20;
  localparam logic [15:0] S_1V   = 16'h03E8;
  localparam logic [15:0] W_4V   = 16'h0FA0;
  localparam logic [15:0] W_5V   = 16'h1388;
  localparam logic [15:0] S_2V   = 16'h07D0;
  localparam logic [15:0] W_8V   = 16'h1F40;
  localparam logic [15:0] W_10V  = 16'h2710;
  localparam logic [15:0] ZERO16 = 16'h0000;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    RNG_4_20MA, RNG_0_20MA, RNG_1_5V, RNG_0_5V, RNG_2_10V, RNG_0_10V
  } acs_range_t;

  typedef enum logic [1:0] {
    CHR_LINEAR, CHR_SQUARE, CHR_SQRT, CHR_USER
  } acs_char_t;

  typedef struct packed {
    acs_range_t         range;
    acs_char_t          charac;
    logic signed [15:0] cal_low_value;
    logic signed [15:0] cal_high_value;
    logic [9:0]         range_extension_low_pct;
    logic [7:0]         range_extension_high_pct;
    logic [4:0]         npts;
  } acs_cfg_t;

  typedef struct packed {
    logic [2:0]  ch;
    logic [15:0] value;
  } acs_sample_t;

  typedef struct packed {
    logic [2:0]  ch;
    logic [15:0] value;
  } acs_result_t;

  localparam acs_cfg_t CFG_RESET = '{
    range: RNG_4_20MA, charac: CHR_LINEAR,
    cal_low_value: 16'sh0000, cal_high_value: 16'sh03E8,
    range_extension_low_pct: 10'h000,
    range_extension_high_pct: 8'h00, npts: 5'h02};

  // Illegal range codes fall back to a zero based span
  function automatic logic [15:0] rng_start(acs_range_t r);
    unique case (r)
      RNG_4_20MA: rng_start = S_4MA; // R1
      RNG_1_5V:   rng_start = S_1V;  // R14
      RNG_2_10V:  rng_start = S_2V;  // R14
      default:    rng_start = ZERO16; // R2
    endcase
  endfunction

  function automatic logic [15:0] rng_span(acs_range_t r);
    unique case (r)
      RNG_4_20MA: rng_span = W_16MA; // R1
      RNG_0_20MA: rng_span = W_20MA; // R2
      RNG_1_5V:   rng_span = W_4V;   // R14
      RNG_0_5V:   rng_span = W_5V;   // R14
      RNG_2_10V:  rng_span = W_8V;   // R14
      RNG_0_10V:  rng_span = W_10V;  // R14
      default:    rng_span = W_20MA;
    endcase
  endfunction
endpackage

// >>> hw/acs_div.sv
// Iterative restoring divider shared by normalizer and curve
`timescale 1ns/1ps
`default_nettype none
module acs_div (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Request
  input  wire logic        start,
  input  wire logic [47:0] dividend,
  input  wire logic [15:0] divisor,
  // Answer
  output logic             done,
  output logic [47:0]      quotient
);
  logic [47:0] quo_reg;
  logic [15:0] rem_reg;
  logic [15:0] den_reg;
  logic [5:0]  cnt_reg;
  logic        done_reg;

  wire [16:0] rem_sh  = {rem_reg, quo_reg[47]};
  wire        rem_ge  = rem_sh >= {1'b0, den_reg};
  wire [16:0] rem_dif = rem_sh - {1'b0, den_reg};
  wire        busy    = cnt_reg != 6'h00;

  // Zero divisor yields all ones, saturated downstream
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      quo_reg  <= 48'h0000_0000_0000;
      rem_reg  <= 16'h0000;
      den_reg  <= 16'h0000;
      cnt_reg  <= 6'h00;
      done_reg <= 1'b0;
    end
    else if (start)
    begin
      quo_reg  <= dividend;
      rem_reg  <= 16'h0000;
      den_reg  <= divisor;
      cnt_reg  <= acs_pkg::DIV_COUNT;
      done_reg <= 1'b0;
    end
    else if (busy)
    begin
      quo_reg  <= {quo_reg[46:0], rem_ge};
      rem_reg  <= rem_ge ? rem_dif[15:0] : rem_sh[15:0];
      cnt_reg  <= cnt_reg - 6'h01;
      done_reg <= cnt_reg == 6'h01;
    end
    else
    begin
      done_reg <= 1'b0;
    end
  end

  assign done     = done_reg;
  assign quotient = quo_reg;
endmodule // acs_div
`default_nettype wire

// >>> hw/acs_scaler.sv
// Channel scaling engine with its register file
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - 4-20 mA: minus 4 mA, over 16 mA
// R2 - 0-20 mA: start zero, over 20 mA
// R3 - Out-of-nominal inputs use same formula, unclamped
// R4 - Linear: n times (high minus low) plus low
// R5 - Low above high inverts slope naturally
// R6 - Square: square n, then linear scaling
// R7 - Root: root of nonnegative n, then scaling
// R8 - Root with negative n returns low value
// R9 - User curve has 2 to 20 points
// R10 - Pick segment whose X bracket holds n
// R11 - Interpolate inside the selected segment
// R12 - Beyond points, extend first or last segment
// R13 - Borders: start minus low pct, end plus high
// R14 - Voltage ranges use their own start, span
// R15 - Host stores all curve points before use
// R16 - Beyond permissible range sets channel status bit
// R17 - Zero-based ranges: lower border fixed zero
// R18 - Calibration values are signed -999 to 9999
// R19 - Curve X is signed, tenth-percent units
// R20 - Round, saturate to 16 bits, store
module acs_scaler (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  // Samples from the front end
  input  wire logic                 sample_valid,
  output logic                      sample_ready,
  input  wire acs_pkg::acs_sample_t sample,
  // Computed results
  output logic                      result_valid,
  output acs_pkg::acs_result_t      result,
  // Register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [15:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [15:0]               reg_rdata
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_NORM, ST_NORM_WAIT, ST_CHAR, ST_SQRT,
    ST_SCALE, ST_SEG, ST_SEG_WAIT, ST_WRITE
  } acs_state_t;

  acs_state_t           state_reg;
  acs_state_t           state_next;
  acs_pkg::acs_cfg_t    cfg_reg [acs_pkg::NUM_CH];
  logic signed [15:0]   px_reg  [acs_pkg::NUM_PTS];
  logic signed [15:0]   py_reg  [acs_pkg::NUM_PTS];
  logic signed [15:0]   res_reg [acs_pkg::NUM_CH];
  logic [7:0]           status_reg;
  logic [15:0]          rdata_reg;
  logic                 rvalid_reg;
  acs_pkg::acs_result_t rslt_reg;
  logic [2:0]           ch_reg;
  logic [15:0]          meas_reg;
  logic signed [31:0]   n_reg;
  logic signed [31:0]   f_reg;
  logic [37:0]          rad_reg;
  logic [18:0]          root_reg;
  logic [4:0]           sbit_reg;
  logic [4:0]           k_reg;
  logic                 neg_reg;
  logic signed [47:0]   w_reg;

  // ==========================================================
  // Register decode
  wire in_res = reg_addr >= acs_pkg::A_RES_FIRST
             && reg_addr <= acs_pkg::A_RES_LAST;
  wire in_cfg = reg_addr >= acs_pkg::A_CFG_FIRST
             && reg_addr <= acs_pkg::A_CFG_LAST;
  wire in_pt  = reg_addr >= acs_pkg::A_PT_FIRST
             && reg_addr <= acs_pkg::A_PT_LAST;
  wire       in_st   = reg_addr == acs_pkg::A_STATUS;
  wire [7:0] res_off = reg_addr - acs_pkg::A_RES_FIRST;
  wire [7:0] cfg_off = reg_addr - acs_pkg::A_CFG_FIRST;
  wire [7:0] pt_off  = reg_addr - acs_pkg::A_PT_FIRST;
  wire [2:0] cfg_ch  = cfg_off[5:3];
  wire [2:0] cfg_fld = cfg_off[2:0];
  wire [4:0] pt_idx  = pt_off[5:1];
  wire       cfg_wr  = reg_wr && in_cfg;
  wire       pt_wr   = reg_wr && in_pt;
  wire       st_clr  = reg_wr && in_st;

  acs_pkg::acs_cfg_t rd_cfg;
  assign rd_cfg = cfg_reg[cfg_ch];

  wire [15:0] cfg_word =
    (cfg_fld == acs_pkg::F_RANGE)  ? {13'h0, rd_cfg.range} :
    (cfg_fld == acs_pkg::F_CHAR)   ? {14'h0, rd_cfg.charac} :
    (cfg_fld == acs_pkg::F_CAL_LO) ? rd_cfg.cal_low_value :
    (cfg_fld == acs_pkg::F_CAL_HI) ? rd_cfg.cal_high_value :
    (cfg_fld == acs_pkg::F_EXT_LO) ?
      {6'h00, rd_cfg.range_extension_low_pct} :
    (cfg_fld == acs_pkg::F_EXT_HI) ?
      {8'h00, rd_cfg.range_extension_high_pct} :
    (cfg_fld == acs_pkg::F_NPTS)   ? {11'h0, rd_cfg.npts} :
    16'h0000;
  wire [15:0] pt_word = pt_off[0] ? py_reg[pt_idx] : px_reg[pt_idx];
  wire [15:0] rd_word =
    in_res ? res_reg[res_off[2:0]] :
    in_st  ? {8'h00, status_reg} :
    in_cfg ? cfg_word :
    in_pt  ? pt_word : 16'h0000;

  // ==========================================================
  // Normalization and permissible range
  acs_pkg::acs_cfg_t cur;
  assign cur = cfg_reg[ch_reg];
  wire [15:0] rng_start = acs_pkg::rng_start(cur.range);
  wire [15:0] rng_span  = acs_pkg::rng_span(cur.range);
  wire        live_zero = rng_start != acs_pkg::ZERO16;
  wire signed [16:0] diff = $signed({1'b0, meas_reg})
                          - $signed({1'b0, rng_start}); // R1
  wire [16:0] diff_mag = diff[16] ? -diff : diff;
  wire [15:0] ext_lo = {6'h00, cur.range_extension_low_pct};
  wire [15:0] lo_fac = (ext_lo > acs_pkg::PCT_SCALE) ? 16'h0000
                     : acs_pkg::PCT_SCALE - ext_lo;
  wire [15:0] hi_fac = acs_pkg::PCT_SCALE
                     + {8'h00, cur.range_extension_high_pct};
  wire [31:0] meas_k  = meas_reg * acs_pkg::PCT_SCALE;
  wire [31:0] lo_lim  = rng_start * lo_fac; // R13
  wire [16:0] rng_end = {1'b0, rng_start} + {1'b0, rng_span};
  wire [32:0] hi_lim  = rng_end * hi_fac; // R13
  wire under   = live_zero && meas_k < lo_lim; // R17
  wire over    = {1'b0, meas_k} > hi_lim;
  wire out_rng = under || over;

  wire [7:0] st_set = (state_reg == ST_NORM && out_rng)
                    ? 8'h01 << ch_reg : 8'h00; // R16
  wire [7:0] st_wclr = st_clr ? reg_wdata[7:0] : 8'h00;
  // Set wins over a clear in the same cycle
  wire [7:0] st_next = (status_reg & ~st_wclr) | st_set; // R16

  // ==========================================================
  // Characteristics
  wire signed [15:0] cal_lo_s = cur.cal_low_value; // R18
  wire signed [15:0] cal_hi_s = cur.cal_high_value; // R18
  wire signed [16:0] cal_span = $signed({cal_hi_s[15], cal_hi_s})
                              - $signed({cal_lo_s[15], cal_lo_s}); // R5
  wire signed [63:0] sq_full  = n_reg * n_reg; // R6
  wire signed [31:0] n_sq     = $signed(sq_full[47:16]);
  wire [18:0] s_try  = root_reg | (19'h0_0001 << sbit_reg);
  wire [37:0] s_sq   = s_try * s_try;
  wire        s_keep = s_sq <= rad_reg; // R7
  wire [18:0] s_root = s_keep ? s_try : root_reg;
  wire signed [48:0] half49 = $signed({33'h0, acs_pkg::ROUND_HALF});
  wire signed [48:0] sc_prod = f_reg * cal_span; // R4
  wire signed [48:0] sc_rnd  = sc_prod + half49; // R20
  wire signed [47:0] w_lin = 48'($signed(sc_rnd[48:16]))
                           + 48'(cal_lo_s); // R4

  // ==========================================================
  // User curve segment search and interpolation
  wire [4:0] npts_eff =
    (cur.npts < acs_pkg::MIN_PTS) ? acs_pkg::MIN_PTS :
    (cur.npts > acs_pkg::MAX_PTS) ? acs_pkg::MAX_PTS : cur.npts; // R9
  wire [4:0] last_k = npts_eff - acs_pkg::MIN_PTS;
  wire [4:0] k_up   = k_reg + 5'h01;
  wire signed [15:0] segment_lower_point_x = px_reg[k_reg]; // R19
  wire signed [15:0] segment_upper_point_x = px_reg[k_up];
  wire signed [15:0] segment_lower_point_y = py_reg[k_reg];
  wire signed [15:0] segment_upper_point_y = py_reg[k_up];
  wire signed [48:0] nx = n_reg * $signed({1'b0, acs_pkg::PCT_SCALE});
  wire signed [48:0] segment_base_normalized =
    49'($signed({segment_lower_point_x, 16'h0000}));
  wire signed [48:0] upper_q =
    49'($signed({segment_upper_point_x, 16'h0000}));
  // Scan assumes X rises point to point
  wire seg_hit = (k_reg == last_k) || (nx < upper_q); // R10 R12 R15
  wire signed [48:0] dnx = nx - segment_base_normalized; // R11
  wire signed [16:0] dy =
    $signed({segment_upper_point_y[15], segment_upper_point_y})
    - $signed({segment_lower_point_y[15], segment_lower_point_y});
  wire signed [16:0] dx =
    $signed({segment_upper_point_x[15], segment_upper_point_x})
    - $signed({segment_lower_point_x[15], segment_lower_point_x});
  wire signed [65:0] seg_num = dnx * dy; // R11
  wire        seg_neg = seg_num[65] ^ dx[16];
  wire [65:0] seg_abs = seg_num[65] ? -seg_num : seg_num;
  wire [16:0] dx_abs  = dx[16] ? -dx : dx;

  // ==========================================================
  // Shared divider
  wire        div_done;
  wire [47:0] div_q;
  wire        div_go  = state_reg == ST_NORM
                     || (state_reg == ST_SEG && seg_hit);
  wire [47:0] div_num = (state_reg == ST_SEG) ? seg_abs[47:0]
                      : {15'h0000, diff_mag, 16'h0000}; // R1 R2
  wire [15:0] div_den = (state_reg == ST_SEG) ? dx_abs[15:0]
                      : rng_span; // R14

  acs_div u_div (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .start    (div_go),
    .dividend (div_num),
    .divisor  (div_den),
    .done     (div_done),
    .quotient (div_q)
  );

  wire signed [48:0] q_pos = $signed({1'b0, div_q});
  wire signed [48:0] q_s   = neg_reg ? -q_pos : q_pos; // R3
  wire signed [48:0] q_rnd = q_s + half49; // R20
  wire signed [47:0] w_seg = 48'($signed(q_rnd[48:16]))
                           + 48'(segment_lower_point_y); // R11
  wire [15:0] w_sat =
    (w_reg > 48'(acs_pkg::SAT_MAX)) ? acs_pkg::SAT_MAX :
    (w_reg < 48'(acs_pkg::SAT_MIN)) ? acs_pkg::SAT_MIN :
    w_reg[15:0]; // R20

  // ==========================================================
  // Sequencer
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:      if (sample_valid) state_next = ST_NORM;
      ST_NORM:      state_next = ST_NORM_WAIT;
      ST_NORM_WAIT: if (div_done) state_next = ST_CHAR;
      ST_CHAR:
        unique case (cur.charac)
          acs_pkg::CHR_LINEAR: state_next = ST_SCALE;
          acs_pkg::CHR_SQUARE: state_next = ST_SCALE;
          acs_pkg::CHR_SQRT:
            state_next = n_reg[31] ? ST_WRITE : ST_SQRT; // R8
          acs_pkg::CHR_USER:   state_next = ST_SEG;
        endcase
      ST_SQRT:      if (sbit_reg == 5'h00) state_next = ST_SCALE;
      ST_SCALE:     state_next = ST_WRITE;
      ST_SEG:       if (seg_hit) state_next = ST_SEG_WAIT;
      ST_SEG_WAIT:  if (div_done) state_next = ST_WRITE;
      ST_WRITE:     state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg  <= ST_IDLE;
      status_reg <= 8'h00;
      rdata_reg  <= 16'h0000;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      status_reg <= st_next;
      rdata_reg  <= reg_rd ? rd_word : 16'h0000;
      rvalid_reg <= state_reg == ST_WRITE;
    end
  end

  // Datapath registers
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ch_reg   <= 3'h0;
      meas_reg <= 16'h0000;
      n_reg    <= 32'sh0000_0000;
      f_reg    <= 32'sh0000_0000;
      rad_reg  <= 38'h00_0000_0000;
      root_reg <= 19'h0_0000;
      sbit_reg <= 5'h00;
      k_reg    <= 5'h00;
      neg_reg  <= 1'b0;
      w_reg    <= 48'sh0000_0000_0000;
      rslt_reg <= '0;
      for (int i = 0; i < acs_pkg::NUM_CH; i++)
        res_reg[i] <= 16'sh0000;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
          if (sample_valid)
          begin
            ch_reg   <= sample.ch;
            meas_reg <= sample.value;
          end
        ST_NORM:      neg_reg <= diff[16];
        ST_NORM_WAIT: if (div_done) n_reg <= q_s[31:0]; // R3
        ST_CHAR:
        begin
          f_reg    <= (cur.charac == acs_pkg::CHR_SQUARE)
                      ? n_sq : n_reg; // R6
          rad_reg  <= {n_reg[21:0], 16'h0000};
          root_reg <= 19'h0_0000;
          sbit_reg <= acs_pkg::SQRT_TOP;
          k_reg    <= 5'h00;
          w_reg    <= 48'(cal_lo_s); // R8
        end
        ST_SQRT:
        begin
          root_reg <= s_root;
          sbit_reg <= sbit_reg - 5'h01;
          f_reg    <= $signed({13'h0000, s_root}); // R7
        end
        ST_SCALE:     w_reg <= w_lin;
        ST_SEG:
          if (seg_hit) neg_reg <= seg_neg;
          else k_reg <= k_up; // R10
        ST_SEG_WAIT:  if (div_done) w_reg <= w_seg;
        ST_WRITE:
        begin
          res_reg[ch_reg] <= w_sat; // R20
          rslt_reg <= '{ch: ch_reg, value: w_sat};
        end
      endcase
    end
  end

  // ==========================================================
  // Configuration and curve storage
  for (genvar c = 0; c < acs_pkg::NUM_CH; c++)
  begin : g_cfg
    wire sel = cfg_wr && cfg_ch == 3'(c);
    always_ff @(posedge clk_sys or negedge resetn)
    begin
      if (!resetn)
        cfg_reg[c] <= acs_pkg::CFG_RESET;
      else if (sel)
        unique case (cfg_fld)
          acs_pkg::F_RANGE:
            cfg_reg[c].range <= acs_pkg::acs_range_t'(reg_wdata[2:0]);
          acs_pkg::F_CHAR:
            cfg_reg[c].charac <= acs_pkg::acs_char_t'(reg_wdata[1:0]);
          acs_pkg::F_CAL_LO: cfg_reg[c].cal_low_value  <= reg_wdata;
          acs_pkg::F_CAL_HI: cfg_reg[c].cal_high_value <= reg_wdata;
          acs_pkg::F_EXT_LO:
            cfg_reg[c].range_extension_low_pct <= reg_wdata[9:0];
          acs_pkg::F_EXT_HI:
            cfg_reg[c].range_extension_high_pct <= reg_wdata[7:0];
          acs_pkg::F_NPTS: cfg_reg[c].npts <= reg_wdata[4:0];
          default: ;
        endcase
    end
  end

  // Points are not checked; a curve in progress gives odd results
  for (genvar p = 0; p < acs_pkg::NUM_PTS; p++)
  begin : g_pt
    wire sel = pt_wr && pt_idx == 5'(p);
    always_ff @(posedge clk_sys or negedge resetn)
    begin
      if (!resetn)
      begin
        px_reg[p] <= 16'sh0000;
        py_reg[p] <= 16'sh0000;
      end
      else if (sel && pt_off[0])
        py_reg[p] <= reg_wdata;
      else if (sel)
        px_reg[p] <= reg_wdata; // R19
    end
  end

  assign sample_ready = state_reg == ST_IDLE;
  assign result_valid = rvalid_reg;
  assign result       = rslt_reg;
  assign reg_rdata    = rdata_reg;
endmodule // acs_scaler
`default_nettype wire

// >>> dv/acs_frontend.sv
// Front end model that offers measured samples
`timescale 1ns/1ps
`default_nettype none
module acs_frontend (
  // Clock
  input  wire logic            clk_sys,
  // Handshake
  input  wire logic            sample_ready,
  output logic                 sample_valid,
  output acs_pkg::acs_sample_t sample
);
  initial
  begin
    sample_valid = 1'b0;
    sample       = '0;
  end

  // Called just after an edge; holds the offer until taken
  task automatic send(input logic [2:0] ch, input logic [15:0] v);
    sample_valid <= 1'b1;
    sample       <= '{ch: ch, value: v};
    do @(posedge clk_sys); while (sample_ready !== 1'b1);
    sample_valid <= 1'b0;
    // Released data scrambled so no stale value looks valid
    sample       <= '{ch: ~ch, value: ~v};
  endtask
endmodule // acs_frontend
`default_nettype wire

// >>> dv/acs_scaler_chk.sv
// Port checks of the scaling engine
`timescale 1ns/1ps
`default_nettype none
module acs_scaler_chk (
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 resetn,
  // Samples and results
  input wire logic                 sample_valid,
  input wire logic                 sample_ready,
  input wire acs_pkg::acs_sample_t sample,
  input wire logic                 result_valid,
  input wire acs_pkg::acs_result_t result,
  // Register port
  input wire logic [7:0]           reg_addr,
  input wire logic [15:0]          reg_wdata,
  input wire logic                 reg_wr,
  input wire logic                 reg_rd,
  input wire logic [15:0]          reg_rdata
);
  // ==========================================================
  // Timing
  localparam int LAT_MIN = 52;
  localparam int LAT_MAX = 121;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_take;
    sample_valid && sample_ready;
  endsequence
  sequence s_answer;
    ##[LAT_MIN:LAT_MAX] result_valid;
  endsequence

  // ==========================================================
  // Properties
  a_result_in_window: assert property (s_take |-> s_answer)
    else $error("no result within latency window");
  a_valid_one_pulse: assert property (result_valid |=> !result_valid)
    else $error("result valid longer than one cycle");
  a_busy_not_ready: assert property (s_take |=> !sample_ready[*8])
    else $error("ready while computing");
  a_ready_with_result: assert property (result_valid |-> sample_ready)
    else $error("not ready when result appears");
  a_result_holds: assert property (!result_valid |-> $stable(result))
    else $error("result changed without valid");
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> !reg_rdata)
    else $error("read data outside read answer cycle");
  a_result_reg_match: assert property (reg_rd && reg_addr ==
      acs_pkg::A_RES_FIRST + {5'h00, result.ch}
      |=> reg_rdata == $past(result.value))
    else $error("result register differs from last result");
  a_status_high_zero: assert property (reg_rd &&
      reg_addr == acs_pkg::A_STATUS |=> reg_rdata[15:8] == 8'h00)
    else $error("status upper byte not zero");
endmodule // acs_scaler_chk

bind acs_scaler acs_scaler_chk acs_scaler_chk_inst (
  .clk_sys(clk_sys), .resetn(resetn), .sample_valid(sample_valid),
  .sample_ready(sample_ready), .sample(sample),
  .result_valid(result_valid), .result(result), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata));
`default_nettype wire

// >>> dv/acs_scaler_tb.sv
// Self-checking bench of the scaling engine
`timescale 1ns/1ps
`default_nettype none
module acs_scaler_tb;
  logic                 clk_sys, resetn, sample_valid, sample_ready;
  logic                 result_valid, reg_wr, reg_rd;
  logic [7:0]           reg_addr;
  logic [15:0]          reg_wdata, reg_rdata;
  acs_pkg::acs_sample_t sample;
  acs_pkg::acs_result_t result;
  int                   miscompares = 0;
  int                   samples_checked = 0;
  int                   cycles = 0;
  localparam int        TIMEOUT = 20000;

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  acs_scaler acs_scaler_inst (.clk_sys(clk_sys), .resetn(resetn),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample(sample), .result_valid(result_valid), .result(result),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  acs_frontend acs_frontend_inst (.clk_sys(clk_sys),
    .sample_ready(sample_ready), .sample_valid(sample_valid),
    .sample(sample));

  // ==========================================================
  // Helpers
  task summarize;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == TIMEOUT)
    begin
      miscompares++;
      summarize;
    end
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] ca(input logic [2:0] c, input logic [2:0] f);
    return acs_pkg::A_CFG_FIRST + {2'b00, c, f};
  endfunction

  // Idle cycle after each strobe keeps one assignment per time step
  task wr(input logic [7:0] a, input logic [15:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    @(posedge clk_sys);
  endtask

  task rd(input logic [7:0] a, output logic [15:0] d);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask

  task set_ch(input logic [2:0] c, input logic [15:0] rng, chr, lo, hi);
    wr(ca(c, acs_pkg::F_RANGE), rng);
    wr(ca(c, acs_pkg::F_CHAR), chr);
    wr(ca(c, acs_pkg::F_CAL_LO), lo);
    wr(ca(c, acs_pkg::F_CAL_HI), hi);
  endtask

  task run(input logic [2:0] c, input logic [15:0] v);
    int n;
    n = 0;
    acs_frontend_inst.send(c, v);
    while (result_valid !== 1'b1 && n < 200)
    begin
      @(posedge clk_sys);
      n++;
    end
    check({15'h0000, result_valid}, 16'h0001);
  endtask

  task meas(input logic [2:0] c, input logic [15:0] v, input logic [15:0] e);
    logic [15:0] d;
    run(c, v);
    check(result.value, e);
    check({13'h0000, result.ch}, {13'h0000, c});
    rd(acs_pkg::A_RES_FIRST + {5'h00, c}, d);
    check(d, e);
  endtask

  task st(input logic [15:0] e);
    logic [15:0] d;
    rd(acs_pkg::A_STATUS, d);
    check(d, e);
  endtask

  // ==========================================================
  // Scenarios
  task t_reset;
    logic [15:0] d;
    rd(ca(3'h0, acs_pkg::F_CAL_HI), d);
    check(d, 16'h03E8);
    rd(ca(3'h0, acs_pkg::F_NPTS), d);
    check(d, 16'h0002);
    rd(ca(3'h0, 3'h7), d);
    check(d, 16'h0000);
    rd(8'hFF, d);
    check(d, 16'h0000);
    st(16'h0000);
  endtask

  task t_linear;
    set_ch(3'h0, 16'h0000, 16'h0000, 16'h012C, 16'h04B0);
    meas(3'h0, 16'h2EE0, 16'h02EE);
    meas(3'h0, 16'h5DC0, 16'h0591);
    st(16'h0001);
    wr(acs_pkg::A_STATUS, 16'h0001);
    st(16'h0000);
    set_ch(3'h1, 16'h0000, 16'h0000, 16'h04B0, 16'h012C);
    meas(3'h1, 16'h1F40, 16'h03CF);
    set_ch(3'h4, 16'h0001, 16'h0000, 16'h012C, 16'h04B0);
    meas(3'h4, 16'h1388, 16'h020D);
    wr(ca(3'h6, acs_pkg::F_RANGE), 16'h0002);
    meas(3'h6, 16'h0BB8, 16'h01F4);
    wr(ca(3'h6, acs_pkg::F_RANGE), 16'h0003);
    meas(3'h6, 16'h03E8, 16'h00C8);
    wr(ca(3'h6, acs_pkg::F_RANGE), 16'h0004);
    meas(3'h6, 16'h0FA0, 16'h00FA);
    wr(ca(3'h6, acs_pkg::F_RANGE), 16'h0005);
    meas(3'h6, 16'h1D4C, 16'h02EE);
  endtask

  task t_curves;
    set_ch(3'h2, 16'h0000, 16'h0001, 16'h012C, 16'h04B0);
    meas(3'h2, 16'h2EE0, 16'h020D);
    set_ch(3'h3, 16'h0000, 16'h0002, 16'h012C, 16'h04B0);
    meas(3'h3, 16'h1F40, 16'h02EE);
    meas(3'h3, 16'h07D0, 16'h012C);
  endtask

  task t_user;
    logic [15:0] pts [6];
    pts = '{16'h0000, 16'h0000, 16'h01F4, 16'h0064, 16'h03E8, 16'h03E8};
    for (int i = 0; i < 6; i++)
      wr(acs_pkg::A_PT_FIRST + 8'(i), pts[i]);
    set_ch(3'h7, 16'h0000, 16'h0003, 16'h0000, 16'h0000);
    wr(ca(3'h7, acs_pkg::F_NPTS), 16'h0003);
    meas(3'h7, 16'h3E80, 16'h0226);
    meas(3'h7, 16'h07D0, 16'hFFE7);
    meas(3'h7, 16'h5DC0, 16'h05AA);
  endtask

  task t_borders;
    wr(acs_pkg::A_STATUS, 16'h00FF);
    wr(ca(3'h5, acs_pkg::F_EXT_LO), 16'h00C8);
    wr(ca(3'h5, acs_pkg::F_EXT_HI), 16'h0064);
    run(3'h5, 16'h0CE4);
    st(16'h0000);
    run(3'h5, 16'h0C1C);
    st(16'h0020);
    wr(acs_pkg::A_STATUS, 16'h0020);
    run(3'h5, 16'h558C);
    st(16'h0000);
    run(3'h5, 16'h5654);
    st(16'h0020);
  endtask

  initial
  begin
    resetn    = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_linear;
    t_curves;
    t_user;
    t_borders;
    summarize;
  end
endmodule // acs_scaler_tb
`default_nettype wire
